// ===== logic/adc_regs_pkg.sv
// adc_regs_pkg: offsets, bit positions, reset values and mode codes of the
// converter status and mode registers.
// assumes an 8-bit special-function bus with byte and single-bit access.
// Overview of operation
// - primary done flag, status bit 7, sets on conversion or calibration end
// - primary done clears on a zero write or a calibration-start mode write
// - set primary done flag blocks result and coefficient updates
// - status bit 6 is the auxiliary done flag, same behaviour as primary
// - calibration-done flag, status bit 5, sets when a calibration ends
// - calibration-done clears only on a start mode write, never directly
// - auxiliary calibration with temperature sensor selected never completes
// - bit 4 shows primary reference missing while a converter runs
// - while reference missing, every written result is forced to all ones
// - reference-missing flag held at zero while reference is valid
// - primary error, bit 3, sets when a written result was clamped
// - primary error also sets when a calibration failed to write coefficients
// - primary error clears on a conversion- or calibration-start mode write
// - status bit 2 is the auxiliary error flag, same as primary
// - status bits 1 and 0 unimplemented, writes to them ignored
// - mode register at D1H, resets to 08H, no single-bit access
// - status register at D8H, resets to 00H, single-bit access allowed
// - mode bit 6 selects 60 Hz notch, effective only if decimation >= 68
// - mode bit 5 powers the primary converter up, clear powers it down
package adc_regs_pkg;
  localparam logic [7:0] MODE_ADDR = 8'hD1;
  localparam logic [7:0] STAT_ADDR = 8'hD8;
  localparam logic [7:0] MODE_RESET = 8'h08;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h7F;
  localparam int STAT_PRIMARY_DONE_BIT = 7;
  localparam int STAT_AUX_DONE_BIT = 6;
  localparam int STAT_CAL_BIT = 5;
  localparam int STAT_NOREF_BIT = 4;
  localparam int STAT_PRIMARY_ERR_BIT = 3;
  localparam int STAT_AUX_ERR_BIT = 2;
  localparam int MODE_NOTCH_BIT = 6;
  localparam int MODE_EN0_BIT = 5;
  localparam int MODE_EN1_BIT = 4;
  localparam int MODE_MD_LSB = 0;
  localparam int MODE_MD_W = 3;
  localparam logic [7:0] NOTCH_MIN_DECIM = 8'h44;
  localparam logic [2:0] MD_POWER_DOWN = 3'h0;
  localparam logic [2:0] MD_IDLE = 3'h1;
  localparam logic [2:0] MD_SINGLE = 3'h2;
  localparam logic [2:0] MD_CONT = 3'h3;
  localparam logic [2:0] MD_CAL_FIRST = 3'h4;
  localparam int NUM_CONV = 2;
  localparam int PRIMARY = 0;
  localparam int AUX = 1;
  localparam int RES_W = 24;
endpackage : adc_regs_pkg

// ===== logic/flag_if.sv
// flag_if: events and clears into one converter's flag unit, flags back.
// assumes the driving side already qualified events against blocking.
`timescale 1ns/10ps
interface flag_if;
  logic any_done;
  logic result_wr;
  logic clamp;
  logic cal_fail;
  logic sw_clear;
  logic start_cal;
  logic start_any;
  logic ready;
  logic error;
  modport ctrl (
    output any_done, result_wr, clamp, cal_fail, sw_clear, start_cal, start_any,
    input ready, error
  );
  modport unit (
    input any_done, result_wr, clamp, cal_fail, sw_clear, start_cal, start_any,
    output ready, error
  );
endinterface : flag_if

// ===== logic/conv_flag_unit.sv
// conv_flag_unit: done and error flags of one converter.
// assumes single clock, synchronous reset, clock enable from the top.
`timescale 1ns/10ps
module conv_flag_unit (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  flag_if.unit fl
);
  // done flag: set on completion, cleared by zero write or cal start
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      fl.ready <= 1'b0;
    end else if (ce_in) begin
      if (fl.any_done) begin
        fl.ready <= 1'b1;
      end else if (fl.sw_clear || fl.start_cal) begin
        fl.ready <= 1'b0;
      end
    end
  end

  // error flag: clamped result or failed calibration, cleared by start
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      fl.error <= 1'b0;
    end else if (ce_in) begin
      if ((fl.result_wr && fl.clamp) || fl.cal_fail) begin
        fl.error <= 1'b1;
      end else if (fl.start_any) begin
        fl.error <= 1'b0;
      end
    end
  end
endmodule : conv_flag_unit

// ===== logic/ref_monitor.sv
// ref_monitor: synchronises the reference comparator pin, builds the flag.
// assumes ref_low_in is an asynchronous pin level.
`timescale 1ns/10ps
module ref_monitor (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic ref_low_in,
  input wire logic active_in,
  output logic ref_missing_out
);
  logic sync_a;
  logic sync_b;

  // two-stage synchroniser
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else if (ce_in) begin
      sync_a <= ref_low_in;
      sync_b <= sync_a;
    end
  end

  // flag only while a converter runs, zero when reference valid
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ref_missing_out <= 1'b0;
    end else if (ce_in) begin
      ref_missing_out <= active_in && sync_b;
    end
  end
endmodule : ref_monitor

// ===== logic/adc_status_mode_regs.sv
// adc_status_mode_regs: status and mode registers of the converter pair,
// result gating and clamping, start pulses and notch qualification.
// assumes sequencers and the special-function bus share mclk_in;
// only the reference comparator pin is asynchronous.
`timescale 1ns/10ps
module adc_status_mode_regs #(
  parameter int RES_W = adc_regs_pkg::RES_W
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // byte access to the special-function space
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  // single-bit access
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_wr_in,
  input wire logic bit_rd_in,
  input wire logic bit_wdata_in,
  output logic bit_rdata_out,
  output logic bit_hit_out,
  // filter and input selection from neighbouring registers
  input wire logic [7:0] decimation_word_in,
  input wire logic aux_temp_sel_in,
  // reference comparator pin, asynchronous
  input wire logic ref_low_in,
  // sequencer events, one-cycle pulses
  input wire logic [adc_regs_pkg::NUM_CONV-1:0] conv_done_in,
  input wire logic [adc_regs_pkg::NUM_CONV-1:0] cal_done_in,
  input wire logic [adc_regs_pkg::NUM_CONV-1:0] clamp_in,
  input wire logic [adc_regs_pkg::NUM_CONV-1:0] cal_fail_in,
  input wire logic [adc_regs_pkg::NUM_CONV-1:0][RES_W-1:0] result_in,
  // results and control to the converters
  output logic [adc_regs_pkg::NUM_CONV-1:0][RES_W-1:0] result_out,
  output logic [adc_regs_pkg::NUM_CONV-1:0] result_wr_out,
  output logic [adc_regs_pkg::NUM_CONV-1:0] coef_wr_allow_out,
  output logic [adc_regs_pkg::NUM_CONV-1:0] conv_power_on_out,
  output logic [adc_regs_pkg::NUM_CONV-1:0] start_conv_out,
  output logic [adc_regs_pkg::NUM_CONV-1:0] start_cal_out,
  output logic [adc_regs_pkg::MODE_MD_W-1:0] mode_sel_out,
  output logic notch_effective_out
);
  localparam int NC = adc_regs_pkg::NUM_CONV;
  localparam logic [RES_W-1:0] ALL_ONES = {RES_W{1'b1}};

  logic [7:0] mode_reg;
  logic cal_flag;
  logic ref_missing_flag;
  logic [7:0] status_byte;
  logic [7:0] next_mode;
  logic mode_wr;
  logic stat_wr;
  logic stat_bit_sel;
  logic [2:0] bit_idx;
  logic [2:0] wr_md;
  logic wr_is_cal;
  logic wr_is_conv;
  logic wr_is_start;
  logic [NC-1:0] wr_en;
  logic [NC-1:0] ready;
  logic [NC-1:0] error;
  logic [NC-1:0] cal_eff;
  logic [NC-1:0] accept_result;
  logic [NC-1:0] sw_clear_ready;
  logic any_active;

  flag_if fl[NC] ();

  // bus decode
  assign mode_wr = sfr_wr_in && (sfr_addr_in == adc_regs_pkg::MODE_ADDR);
  assign stat_wr = sfr_wr_in && (sfr_addr_in == adc_regs_pkg::STAT_ADDR);
  assign stat_bit_sel = (bit_addr_in[7:3] == adc_regs_pkg::STAT_ADDR[7:3]);
  assign bit_idx = bit_addr_in[2:0];

  // decode of a written mode byte
  assign wr_md = sfr_wdata_in[adc_regs_pkg::MODE_MD_LSB +: adc_regs_pkg::MODE_MD_W];
  assign wr_is_cal = (wr_md >= adc_regs_pkg::MD_CAL_FIRST);
  assign wr_is_conv = (wr_md == adc_regs_pkg::MD_SINGLE) || (wr_md == adc_regs_pkg::MD_CONT);
  assign wr_is_start = mode_wr && (wr_is_cal || wr_is_conv);
  assign wr_en[adc_regs_pkg::PRIMARY] = sfr_wdata_in[adc_regs_pkg::MODE_EN0_BIT];
  assign wr_en[adc_regs_pkg::AUX] = sfr_wdata_in[adc_regs_pkg::MODE_EN1_BIT];

  // new mode value: top bit never stored
  assign next_mode = sfr_wdata_in & adc_regs_pkg::MODE_WMASK;

  // mode register, byte access only
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      mode_reg <= adc_regs_pkg::MODE_RESET;
    end else if (ce_in) begin
      if (mode_wr) begin
        mode_reg <= next_mode;
      end
    end
  end

  // software clears of the done flags: byte write or bit write of zero
  always_comb begin
    sw_clear_ready = '0;
    if (stat_wr) begin
      sw_clear_ready[adc_regs_pkg::PRIMARY] =
        !sfr_wdata_in[adc_regs_pkg::STAT_PRIMARY_DONE_BIT];
      sw_clear_ready[adc_regs_pkg::AUX] =
        !sfr_wdata_in[adc_regs_pkg::STAT_AUX_DONE_BIT];
    end
    if (bit_wr_in && stat_bit_sel && !bit_wdata_in) begin
      if (bit_idx == 3'(adc_regs_pkg::STAT_PRIMARY_DONE_BIT)) begin
        sw_clear_ready[adc_regs_pkg::PRIMARY] = 1'b1;
      end
      if (bit_idx == 3'(adc_regs_pkg::STAT_AUX_DONE_BIT)) begin
        sw_clear_ready[adc_regs_pkg::AUX] = 1'b1;
      end
    end
  end

  // temperature-sensor calibration on the auxiliary converter never ends
  assign cal_eff[adc_regs_pkg::PRIMARY] = cal_done_in[adc_regs_pkg::PRIMARY];
  assign cal_eff[adc_regs_pkg::AUX] =
    cal_done_in[adc_regs_pkg::AUX] && !aux_temp_sel_in;

  // per-converter flags, result gating and clamping
  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_conv
      // results only taken while the done flag is clear
      assign accept_result[gi] = conv_done_in[gi] && !ready[gi];

      assign fl[gi].any_done = conv_done_in[gi] || cal_eff[gi];
      assign fl[gi].result_wr = accept_result[gi];
      assign fl[gi].clamp = clamp_in[gi] || ref_missing_flag;
      assign fl[gi].cal_fail = cal_eff[gi] && cal_fail_in[gi];
      assign fl[gi].sw_clear = sw_clear_ready[gi];
      assign fl[gi].start_cal = wr_is_start && wr_is_cal && wr_en[gi];
      assign fl[gi].start_any = wr_is_start && wr_en[gi];
      assign ready[gi] = fl[gi].ready;
      assign error[gi] = fl[gi].error;

      conv_flag_unit u_flags (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .fl(fl[gi])
      );

      // result register, forced to all ones without reference
      always_ff @(posedge mclk_in) begin
        if (srst_in) begin
          result_out[gi] <= '0;
        end else if (ce_in) begin
          if (accept_result[gi]) begin
            result_out[gi] <= ref_missing_flag ? ALL_ONES : result_in[gi];
          end
        end
      end

      // one-cycle strobe for each result written
      always_ff @(posedge mclk_in) begin
        if (srst_in) begin
          result_wr_out[gi] <= 1'b0;
        end else if (ce_in) begin
          result_wr_out[gi] <= accept_result[gi];
        end
      end

      // start pulses towards the sequencer
      always_ff @(posedge mclk_in) begin
        if (srst_in) begin
          start_conv_out[gi] <= 1'b0;
          start_cal_out[gi] <= 1'b0;
        end else if (ce_in) begin
          start_conv_out[gi] <= wr_is_start && wr_is_conv && wr_en[gi];
          start_cal_out[gi] <= wr_is_start && wr_is_cal && wr_en[gi];
        end
      end

      // coefficients may only be written while the done flag is clear
      assign coef_wr_allow_out[gi] = !ready[gi];
    end
  endgenerate

  // calibration-done flag: no direct write path at all
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cal_flag <= 1'b0;
    end else if (ce_in) begin
      if (|cal_eff) begin
        cal_flag <= 1'b1;
      end else if (wr_is_start) begin
        cal_flag <= 1'b0;
      end
    end
  end

  // converter power follows the enable bits
  assign conv_power_on_out[adc_regs_pkg::PRIMARY] =
    mode_reg[adc_regs_pkg::MODE_EN0_BIT];
  assign conv_power_on_out[adc_regs_pkg::AUX] = mode_reg[adc_regs_pkg::MODE_EN1_BIT];
  assign any_active = |conv_power_on_out;
  assign mode_sel_out = mode_reg[adc_regs_pkg::MODE_MD_LSB +: adc_regs_pkg::MODE_MD_W];

  // notch only with a slow enough filter
  assign notch_effective_out = mode_reg[adc_regs_pkg::MODE_NOTCH_BIT] &&
    (decimation_word_in >= adc_regs_pkg::NOTCH_MIN_DECIM);

  // reference supervision
  ref_monitor u_ref (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .ref_low_in(ref_low_in),
    .active_in(any_active),
    .ref_missing_out(ref_missing_flag)
  );

  // status byte as software sees it; low two bits read zero
  always_comb begin
    status_byte = adc_regs_pkg::STAT_RESET;
    status_byte[adc_regs_pkg::STAT_PRIMARY_DONE_BIT] = ready[adc_regs_pkg::PRIMARY];
    status_byte[adc_regs_pkg::STAT_AUX_DONE_BIT] = ready[adc_regs_pkg::AUX];
    status_byte[adc_regs_pkg::STAT_CAL_BIT] = cal_flag;
    status_byte[adc_regs_pkg::STAT_NOREF_BIT] = ref_missing_flag;
    status_byte[adc_regs_pkg::STAT_PRIMARY_ERR_BIT] = error[adc_regs_pkg::PRIMARY];
    status_byte[adc_regs_pkg::STAT_AUX_ERR_BIT] = error[adc_regs_pkg::AUX];
  end

  // byte read port, registered
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sfr_rdata_out <= 8'h00;
      sfr_hit_out <= 1'b0;
    end else if (ce_in) begin
      sfr_hit_out <= 1'b0;
      sfr_rdata_out <= 8'h00;
      if (sfr_rd_in && (sfr_addr_in == adc_regs_pkg::MODE_ADDR)) begin
        sfr_rdata_out <= mode_reg & adc_regs_pkg::MODE_WMASK;
        sfr_hit_out <= 1'b1;
      end else if (sfr_rd_in && (sfr_addr_in == adc_regs_pkg::STAT_ADDR)) begin
        sfr_rdata_out <= status_byte;
        sfr_hit_out <= 1'b1;
      end
    end
  end

  // bit read port: status register only, mode not bit addressable
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      bit_rdata_out <= 1'b0;
      bit_hit_out <= 1'b0;
    end else if (ce_in) begin
      bit_hit_out <= bit_rd_in && stat_bit_sel;
      bit_rdata_out <= bit_rd_in && stat_bit_sel && status_byte[bit_idx];
    end
  end
endmodule : adc_status_mode_regs

// ===== dv/adc_status_mode_regs_properties.sv
// adc_status_mode_regs_properties: port-level checks of the converter registers.
// assumes one clock domain; attached to the design by the bind at the foot.
`timescale 1ns/10ps
module adc_status_mode_regs_properties (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_hit_out,
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_rd_in,
  input wire logic bit_hit_out,
  input wire logic [7:0] decimation_word_in,
  input wire logic [1:0] conv_done_in,
  input wire logic [1:0] cal_done_in,
  input wire logic [1:0] result_wr_out,
  input wire logic [1:0] coef_wr_allow_out,
  input wire logic [1:0] conv_power_on_out,
  input wire logic [1:0] start_cal_out,
  input wire logic notch_effective_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in || !ce_in);
  // byte write to the mode register
  sequence mode_wr;
    sfr_wr_in && sfr_addr_in == adc_regs_pkg::MODE_ADDR;
  endsequence
  // primary calibration start with no competing event
  sequence cal_start0;
    mode_wr ##0 sfr_wdata_in[5] && sfr_wdata_in[2] && !cal_done_in[0] && !conv_done_in[0];
  endsequence
  // primary result accepted while its flag is clear
  sequence take0;
    conv_done_in[0] && coef_wr_allow_out[0];
  endsequence
  chk_take_prim:
    assert property (take0 |=> result_wr_out[0] && !coef_wr_allow_out[0] ##1 !result_wr_out[0])
    else $error("primary result not taken once");
  chk_take_aux:
    assert property (conv_done_in[1] && coef_wr_allow_out[1]
      |=> result_wr_out[1] && !coef_wr_allow_out[1])
    else $error("aux result not taken");
  chk_hold_prim:
    assert property (!coef_wr_allow_out[0] |=> !result_wr_out[0])
    else $error("primary result written while flag set");
  chk_cal_clears:
    assert property (cal_start0 |=> start_cal_out[0] && coef_wr_allow_out[0])
    else $error("calibration start did not clear flag");
  chk_mode_top_zero:
    assert property (sfr_rd_in && sfr_addr_in == adc_regs_pkg::MODE_ADDR
      |=> sfr_hit_out && !sfr_rdata_out[7])
    else $error("mode read bad");
  chk_stat_low_zero:
    assert property (sfr_rd_in && sfr_addr_in == adc_regs_pkg::STAT_ADDR
      |=> sfr_hit_out && sfr_rdata_out[1:0] == 2'h0)
    else $error("status read bad");
  chk_mode_no_bit:
    assert property (bit_rd_in && bit_addr_in[7:3] == 5'h1A |=> !bit_hit_out)
    else $error("bit access hit mode register");
  chk_power_follow:
    assert property (mode_wr
      |=> conv_power_on_out == {$past(sfr_wdata_in[4]), $past(sfr_wdata_in[5])})
    else $error("power enables do not follow mode write");
  chk_notch_gate:
    assert property (notch_effective_out |-> decimation_word_in >= 8'h44)
    else $error("notch on with short decimation");
endmodule : adc_status_mode_regs_properties

bind adc_status_mode_regs adc_status_mode_regs_properties adc_status_mode_regs_properties_inst (
  .mclk_in, .srst_in, .ce_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
  .sfr_rdata_out, .sfr_hit_out, .bit_addr_in, .bit_rd_in, .bit_hit_out, .decimation_word_in,
  .conv_done_in, .cal_done_in, .result_wr_out, .coef_wr_allow_out, .conv_power_on_out,
  .start_cal_out, .notch_effective_out);

// ===== dv/adc_status_mode_regs_tb.sv
// adc_status_mode_regs_tb: self-checking bench for the status and mode registers.
// assumes the checker file is compiled with it; inputs change at falling edges.
`timescale 1ns/10ps
module adc_status_mode_regs_tb;
  localparam logic [7:0] M = adc_regs_pkg::MODE_ADDR;
  localparam logic [7:0] S = adc_regs_pkg::STAT_ADDR;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [7:0] sfr_addr_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] bit_addr_in = 8'h00;
  logic bit_wr_in = 1'b0;
  logic bit_rd_in = 1'b0;
  logic bit_wdata_in = 1'b0;
  logic [7:0] decimation_word_in = 8'h00;
  logic aux_temp_sel_in = 1'b0;
  logic ref_low_in = 1'b0;
  logic [1:0] conv_done_in = 2'h0;
  logic [1:0] cal_done_in = 2'h0;
  logic [1:0] clamp_in = 2'h0;
  logic [1:0] cal_fail_in = 2'h0;
  logic [1:0][23:0] result_in = '0;
  logic [7:0] sfr_rdata_out;
  logic sfr_hit_out, bit_rdata_out, bit_hit_out, notch_effective_out;
  logic [1:0][23:0] result_out;
  logic [1:0] result_wr_out, coef_wr_allow_out, conv_power_on_out, start_conv_out, start_cal_out;
  logic [2:0] mode_sel_out;
  int failures = 0;
  int tests_run = 0;
  logic [23:0] r;
  logic [7:0] w;
  // free-running core clock
  always #20 mclk_in = ~mclk_in;
  adc_status_mode_regs adc_status_mode_regs_inst (
    .mclk_in, .srst_in, .ce_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
    .sfr_rdata_out, .sfr_hit_out, .bit_addr_in, .bit_wr_in, .bit_rd_in, .bit_wdata_in,
    .bit_rdata_out, .bit_hit_out, .decimation_word_in, .aux_temp_sel_in, .ref_low_in,
    .conv_done_in, .cal_done_in, .clamp_in, .cal_fail_in, .result_in, .result_out,
    .result_wr_out, .coef_wr_allow_out, .conv_power_on_out, .start_conv_out,
    .start_cal_out, .mode_sel_out, .notch_effective_out);
  // expected mode readback and notch state
  function automatic logic [7:0] mode_exp(input logic [7:0] v);
    return v & 8'h7F;
  endfunction : mode_exp
  function automatic logic notch_exp(input logic [7:0] v, input logic [7:0] d);
    return v[6] && d >= 8'h44;
  endfunction : notch_exp
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic nx(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : nx
  // byte write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    nx(1);
    sfr_wr_in = 1'b0;
  endtask : wr
  // byte read, answer one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    nx(1);
    sfr_rd_in = 1'b0;
    chk(sfr_hit_out, a == M || a == S);
    chk(sfr_rdata_out, e);
  endtask : rd
  task automatic bw(input logic [7:0] a, input logic d);
    bit_addr_in = a;
    bit_wdata_in = d;
    bit_wr_in = 1'b1;
    nx(1);
    bit_wr_in = 1'b0;
  endtask : bw
  task automatic br(input logic [7:0] a, input logic h, input logic e);
    bit_addr_in = a;
    bit_rd_in = 1'b1;
    nx(1);
    bit_rd_in = 1'b0;
    chk(bit_hit_out, h);
    if (h) chk(bit_rdata_out, e);
  endtask : br
  // one-cycle sequencer events
  task automatic ev(input logic [1:0] cd, kd, cl, cf);
    conv_done_in = cd;
    cal_done_in = kd;
    clamp_in = cl;
    cal_fail_in = cf;
    nx(1);
    conv_done_in = 2'h0;
    cal_done_in = 2'h0;
    clamp_in = 2'h0;
    cal_fail_in = 2'h0;
  endtask : ev
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // hang guard, far beyond the 85 or so cycles the run takes
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  // main sequence
  initial begin
    void'($urandom(32'hDEF0));
    nx(8);
    srst_in = 1'b0;
    rd(M, 8'h08);
    rd(S, 8'h00);
    rd(8'h80, 8'h00);
    br(8'hD3, 1'b0, 1'b0);
    $display("reset test done");
    wr(M, 8'h23);
    chk(start_conv_out, 2'h1);
    r = 24'($urandom);
    result_in[0] = r;
    ev(2'h1, 2'h0, 2'h0, 2'h0);
    chk(result_wr_out, 2'h1);
    chk(result_out[0], r);
    chk(coef_wr_allow_out, 2'h2);
    result_in[0] = ~r;
    ev(2'h1, 2'h0, 2'h0, 2'h0);
    chk(result_wr_out, 2'h0);
    chk(result_out[0], r);
    wr(S, 8'hFF);
    rd(S, 8'h80);
    wr(S, 8'h00);
    rd(S, 8'h00);
    ev(2'h1, 2'h0, 2'h1, 2'h0);
    rd(S, 8'h88);
    wr(M, 8'h23);
    rd(S, 8'h80);
    bw(8'hDF, 1'b0);
    br(8'hDF, 1'b1, 1'b0);
    $display("conversion test done");
    wr(M, 8'h24);
    chk(start_cal_out, 2'h1);
    ev(2'h0, 2'h1, 2'h0, 2'h1);
    rd(S, 8'hA8);
    wr(S, 8'h00);
    rd(S, 8'h28);
    cal_done_in = 2'h1;
    wr(M, 8'h24);
    cal_done_in = 2'h0;
    rd(S, 8'hA0);
    wr(M, 8'h23);
    rd(S, 8'h80);
    wr(S, 8'h00);
    $display("calibration test done");
    wr(M, 8'h14);
    chk(start_cal_out, 2'h2);
    aux_temp_sel_in = 1'b1;
    ev(2'h0, 2'h2, 2'h0, 2'h0);
    rd(S, 8'h00);
    aux_temp_sel_in = 1'b0;
    ev(2'h0, 2'h2, 2'h0, 2'h0);
    rd(S, 8'h60);
    wr(S, 8'h00);
    result_in[1] = r;
    ev(2'h2, 2'h0, 2'h2, 2'h0);
    chk(result_out[1], r);
    // aux done, calibration still pending a start, aux clamp error
    rd(S, 8'h64);
    wr(M, 8'h13);
    rd(S, 8'h40);
    wr(S, 8'h00);
    $display("aux test done");
    wr(M, 8'h03);
    ref_low_in = 1'b1;
    nx(5);
    rd(S, 8'h00);
    wr(M, 8'h23);
    nx(5);
    rd(S, 8'h10);
    ev(2'h1, 2'h0, 2'h0, 2'h0);
    chk(result_out[0], 24'hFFFFFF);
    ref_low_in = 1'b0;
    nx(5);
    rd(S, 8'h88);
    // clock enable low: a status clear must not land
    ce_in = 1'b0;
    wr(S, 8'h00);
    ce_in = 1'b1;
    rd(S, 8'h88);
    $display("reference test done");
    for (int k = 0; k < 8; k++) begin
      w = 8'($urandom);
      decimation_word_in = k < 2 ? 8'h43 + 8'(k) : 8'($urandom);
      if (k < 2) w[6] = 1'b1;
      wr(M, w);
      rd(M, mode_exp(w));
      chk(conv_power_on_out, {w[4], w[5]});
      chk(mode_sel_out, w[2:0]);
      chk(notch_effective_out, notch_exp(w, decimation_word_in));
    end
    $display("mode test done");
    wrap_up();
  end
endmodule : adc_status_mode_regs_tb
